/* File: bench/audio_fault_properties.sv */
// port assertions for the audio input, mute and fault sequencer
// bound to the top module; every check runs on the core clock
module audio_fault_properties
    import audio_fault_pkg::*;
#(
    parameter int RAMP_CYC_32K = 2560,
    parameter int RAMP_CYC_44K = 2048,
    parameter int RAMP_CYC_48K = 1792
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic master_audio_clock,
    input wire logic bit_clock,
    input wire logic frame_clock,
    input wire logic primary_serial_data,
    input wire logic secondary_serial_data,
    input wire logic format_select,
    input wire logic dac_source_select,
    input wire logic mute_n_pin,
    input wire logic powerdown_n_pin,
    input wire logic digital_reset_n,
    input wire logic over_temp_alarm,
    input wire logic under_voltage_alarm,
    input wire logic output_short_alarm,
    input wire logic pwm_left,
    input wire logic pwm_right,
    input wire logic output_off_state,
    input wire logic [WORD_W-1:0] dac_left_out,
    input wire logic [WORD_W-1:0] dac_right_out,
    input wire logic dac_drive_en,
    input wire logic fault_n_o,
    input wire logic fault_n_oe,
    input wire logic [1:0] sample_rate_code,
    input wire logic clock_stopped
);
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic mclk;
        logic [7:0] quiet;
    } quiet_t;
    quiet_t quiet_q;
    quiet_t quiet_d;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // counts core cycles since the master clock pin last moved
    always_comb
    begin
        quiet_d.mclk = master_audio_clock;
        quiet_d.quiet = quiet_q.quiet;
        if (master_audio_clock != quiet_q.mclk || !digital_reset_n)
            quiet_d.quiet = 8'h00;
        else if (quiet_q.quiet != 8'hFF)
            quiet_d.quiet = quiet_q.quiet + 8'h01;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            quiet_q <= '0;
        else
            quiet_q <= quiet_d;
    end

    chk_mute_holds_off: assert property (!mute_n_pin [*4] |-> output_off_state)
        else $error("pwm not off while mute pin low");
    chk_pd_dac_zero: assert property (!powerdown_n_pin [*4] |->
        dac_left_out == '0 && dac_right_out == '0 && !dac_drive_en)
        else $error("dac not off during power-down");
    chk_pd_dac_runs: assert property ((powerdown_n_pin && digital_reset_n)
        [*8] |-> dac_drive_en)
        else $error("dac stopped while powered");
    chk_off_pwm_low: assert property (output_off_state |->
        !pwm_left && !pwm_right)
        else $error("pwm toggles in off state");
    chk_short_latches: assert property ((mute_n_pin && output_short_alarm
        && digital_reset_n) [*8] |-> fault_n_oe && output_off_state)
        else $error("short alarm not latched off");
    chk_latch_holds: assert property ((mute_n_pin && digital_reset_n) [*3]
        ##0 fault_n_oe |=> fault_n_oe)
        else $error("latched fault cleared without mute");
    chk_flag_drain: assert property (fault_n_oe |->
        !fault_n_o && output_off_state)
        else $error("fault flag driven wrong");
    chk_stop_early: assert property ($rose(clock_stopped) |->
        quiet_q.quiet >= 8'h6E)
        else $error("clock stop flagged too soon");
    chk_stop_late: assert property (quiet_q.quiet >= 8'h8C |->
        clock_stopped)
        else $error("clock stop missed");
endmodule

/* File: bench/audio_host_model.sv */
// host audio source: master, bit and frame clocks plus two data lines
// runs on its own delays, unrelated in phase to the core clock
module audio_host_model
    import audio_fault_pkg::*;
(
    input wire logic format_select,
    input wire logic mclk_run,
    input wire logic [WORD_W-1:0] p_left,
    input wire logic [WORD_W-1:0] p_right,
    input wire logic [WORD_W-1:0] s_left,
    input wire logic [WORD_W-1:0] s_right,
    output logic master_audio_clock,
    output logic bit_clock,
    output logic frame_clock,
    output logic primary_serial_data,
    output logic secondary_serial_data
);
    timeunit 1ns;
    timeprecision 100ps;
    int k;
    int idx;

    function automatic logic slot_bit(input logic [WORD_W-1:0] w,
        input int i);
        // bits outside the word carry noise, never a stale copy
        if (i < 0 || i >= WORD_W)
            return ~w[0];
        return w[WORD_W-1-i];
    endfunction

    initial
    begin
        master_audio_clock = 1'b0;
        #5;
        forever
        begin
            #8;
            if (mclk_run)
                master_audio_clock = ~master_audio_clock;
        end
    end

    initial
    begin
        bit_clock = 1'b0;
        frame_clock = 1'b0;
        primary_serial_data = 1'b0;
        secondary_serial_data = 1'b0;
        #7;
        forever
        begin
            for (int b = 0; b < 64; b++)
            begin
                k = b % 32;
                idx = format_select ? k : k - 1;
                bit_clock = 1'b0;
                frame_clock = (b >= 32) ^ format_select;
                primary_serial_data =
                    slot_bit(b < 32 ? p_left : p_right, idx);
                secondary_serial_data =
                    slot_bit(b < 32 ? s_left : s_right, idx);
                #32;
                bit_clock = 1'b1;
                #32;
            end
        end
    end
endmodule

/* File: bench/audio_input_fault_mute_ctrl_test.sv */
// self-checking bench for the audio input, mute and fault sequencer
// host model drives the audio pins; alarms and control pins come from here
module audio_input_fault_mute_ctrl_test
    import audio_fault_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // short ramps keep the run brief; the 64 ns bit clock is the 48k class
    localparam int R48 = 1792;
    localparam int FRAME = 512;
    logic clock, rst, digital_reset_n, mute_n_pin, powerdown_n_pin;
    logic format_select, dac_source_select, mclk_run;
    logic over_temp_alarm, under_voltage_alarm, output_short_alarm;
    logic master_audio_clock, bit_clock, frame_clock;
    logic primary_serial_data, secondary_serial_data;
    logic pwm_left, pwm_right, output_off_state, dac_drive_en;
    logic fault_n_o, fault_n_oe, clock_stopped;
    logic [1:0] sample_rate_code;
    logic [WORD_W-1:0] dac_left_out, dac_right_out;
    logic [WORD_W-1:0] p_left, p_right, s_left, s_right;
    wire fault_line = fault_n_oe ? fault_n_o : 1'b1;
    int checks;
    int fail_count;
    int hl;
    int hr;

    audio_input_fault_mute_ctrl #(.RAMP_CYC_32K(2560),
        .RAMP_CYC_44K(2048), .RAMP_CYC_48K(R48)) uut (.*);
    audio_host_model host (.*);

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input logic [WORD_W-1:0] seen,
        input logic [WORD_W-1:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic probe(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // carrier period is 16 master clock rises, 32 core cycles here
    task automatic duty_count(output int hl_o, output int hr_o);
        hl_o = 0;
        hr_o = 0;
        repeat (128)
        begin
            probe(1);
            hl_o += int'(pwm_left);
            hr_o += int'(pwm_right);
        end
    endtask

    task automatic test_end(input string name);
        $display("test %s done", name);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wait_flag(input int lim);
        int n;
        n = 0;
        while (fault_n_oe !== 1'b1 && n < lim)
        begin
            probe(1);
            n++;
        end
        if (n >= lim)
        begin
            fail_count++;
            test_done();
        end
    endtask

    initial
    begin
        rst = 1'b1;
        digital_reset_n = 1'b0;
        {mute_n_pin, powerdown_n_pin, format_select} = 3'h0;
        {dac_source_select, over_temp_alarm} = 2'h0;
        {under_voltage_alarm, output_short_alarm} = 2'h0;
        mclk_run = 1'b1;
        {p_left, p_right} = {24'h123456, 24'hFEDCBA};
        {s_left, s_right} = {24'h654321, 24'h89ABCD};
        checks = 0;
        fail_count = 0;
        probe(20);
        check(output_off_state, 1'b1);
        check(fault_line, 1'b1);
        check(dac_left_out, 24'h000000);
        check(sample_rate_code, FS_CODE_32K);
        cyc(1);
        rst <= 1'b0;
        digital_reset_n <= 1'b1;
        powerdown_n_pin <= 1'b1;
        // every format and dac source
        for (int i = 0; i < 4; i++)
        begin
            format_select <= i[0];
            dac_source_select <= i[1];
            probe(3 * FRAME);
            check(dac_left_out, i[1] ? s_left : p_left);
            check(dac_right_out, i[1] ? s_right : p_right);
            cyc(1);
        end
        probe(1);
        check(sample_rate_code, FS_CODE_48K);
        check(dac_drive_en, 1'b1);
        cyc(1);
        powerdown_n_pin <= 1'b0;
        probe(5);
        check(dac_right_out, 24'h000000);
        check(dac_drive_en, 1'b0);
        cyc(1);
        powerdown_n_pin <= 1'b1;
        mute_n_pin <= 1'b1;
        probe(2);
        check(output_off_state, 1'b1);
        probe(3);
        check(output_off_state, 1'b0);
        probe(R48 + 50);
        // full gain: duty 10 of 16 left, 7 of 16 right, primary only
        duty_count(hl, hr);
        check(24'(hl), 24'h50);
        check(24'(hr), 24'h38);
        test_end("routing and mute");
        // over-temperature, undervoltage, master clock stop
        for (int k = 0; k < 3; k++)
        begin
            cyc(1);
            over_temp_alarm <= (k == 0);
            under_voltage_alarm <= (k == 1);
            mclk_run <= (k != 2);
            probe(R48 / 2);
            check(output_off_state, 1'b0);
            probe(R48 / 2 + 200);
            check(output_off_state, 1'b1);
            check(fault_line, 1'b1);
            check(clock_stopped, k == 2);
            check(dac_left_out, s_left);
            cyc(1);
            {over_temp_alarm, under_voltage_alarm, mclk_run} <= 3'h1;
            probe(10);
            check(output_off_state, 1'b0);
            probe(R48 + 50);
        end
        test_end("soft faults");
        cyc(1);
        output_short_alarm <= 1'b1;
        probe(4);
        check(output_off_state, 1'b1);
        check(fault_line, 1'b0);
        check(dac_left_out, s_left);
        // hold the short long enough for the latch assertion to see it
        cyc(5);
        output_short_alarm <= 1'b0;
        probe(50);
        check(fault_line, 1'b0);
        cyc(1);
        mute_n_pin <= 1'b0;
        output_short_alarm <= 1'b1;
        probe(10);
        check(fault_line, 1'b1);
        cyc(1);
        output_short_alarm <= 1'b0;
        cyc(4);
        mute_n_pin <= 1'b1;
        probe(8);
        check(fault_line, 1'b1);
        check(output_off_state, 1'b0);
        probe(R48 + 50);
        test_end("output short");
        cyc(1);
        {p_left, p_right} <= {24'h7FFFFF, 24'h7FFFFF};
        probe(R48);
        check(fault_line, 1'b1);
        wait_flag(R48 + 2 * FRAME + 50);
        check(output_off_state, 1'b1);
        cyc(1);
        {p_left, p_right} <= {24'h123456, 24'hFEDCBA};
        mute_n_pin <= 1'b0;
        probe(8);
        check(output_off_state, 1'b1);
        check(fault_line, 1'b1);
        test_end("dc offset");
        test_done();
    end
endmodule

bind audio_input_fault_mute_ctrl audio_fault_properties #(
    .RAMP_CYC_32K(RAMP_CYC_32K),
    .RAMP_CYC_44K(RAMP_CYC_44K),
    .RAMP_CYC_48K(RAMP_CYC_48K)
) props (.*);

/* File: rtl/audio_fault_pkg.sv */
// constants and types for the audio input, mute and fault sequencer
// assumes a 125 MHz core clock independent of the audio master clock
package audio_fault_pkg;

    // core clock
    localparam int CLOCK_MHZ = 125;
    localparam int CLOCK_KHZ = CLOCK_MHZ * 1000;

    // audio rates and ratios
    localparam int FS_HZ_32K = 32000;
    localparam int FS_HZ_44K = 44100;
    localparam int FS_HZ_48K = 48000;
    localparam int MCLK_RATIO = 256;
    localparam int BCLK_RATIO = 64;
    localparam int PWM_HZ_32K = 512000;
    localparam int PWM_HZ_44K = 705600;
    localparam int PWM_HZ_48K = 768000;
    localparam int PWM_RATIO = PWM_HZ_32K / FS_HZ_32K;
    localparam int PWM_DIV = MCLK_RATIO / PWM_RATIO;
    localparam int PWM_PH_W = $clog2(PWM_DIV);

    // frame period in core cycles, and the class boundaries between rates
    localparam int FRAME_CYC_32K = CLOCK_KHZ * 1000 / FS_HZ_32K;
    localparam int FRAME_CYC_44K = CLOCK_KHZ * 1000 / FS_HZ_44K;
    localparam int FRAME_CYC_48K = CLOCK_KHZ * 1000 / FS_HZ_48K;
    localparam int FRAME_W = 13;
    localparam logic [FRAME_W-1:0] FRAME_SPLIT_LO =
        FRAME_W'((FRAME_CYC_32K + FRAME_CYC_44K) / 2);
    localparam logic [FRAME_W-1:0] FRAME_SPLIT_HI =
        FRAME_W'((FRAME_CYC_44K + FRAME_CYC_48K) / 2);

    // sample rate codes
    localparam logic [1:0] FS_CODE_32K = 2'h0;
    localparam logic [1:0] FS_CODE_44K = 2'h1;
    localparam logic [1:0] FS_CODE_48K = 2'h2;

    // ramp and dc qualification times, same per rate
    localparam int RAMP_MS_32K = 64;
    localparam int RAMP_MS_44K = 46;
    localparam int RAMP_MS_48K = 43;
    localparam int RAMP_CYC_32K_DEF = RAMP_MS_32K * CLOCK_KHZ;
    localparam int RAMP_CYC_44K_DEF = RAMP_MS_44K * CLOCK_KHZ;
    localparam int RAMP_CYC_48K_DEF = RAMP_MS_48K * CLOCK_KHZ;
    localparam int TIME_W = 24;

    // master clock stop detection
    localparam int CLK_STOP_NS = 1000;
    localparam int STOP_W = 8;
    localparam logic [STOP_W-1:0] CLK_STOP_CYC =
        STOP_W'(CLK_STOP_NS * CLOCK_MHZ / 1000);

    // sample word, gain and duty
    localparam int WORD_W = 24;
    localparam int IDX_W = 6;
    localparam int GAIN_W = 8;
    localparam int GAIN_STEPS = 256;
    localparam logic [GAIN_W-1:0] GAIN_MAX = 8'hFF;
    localparam int DUTY_W = 5;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 5'h10;
    localparam logic [DUTY_W-1:0] DUTY_ZERO = 5'h00;
    localparam int DUTY_SHIFT = WORD_W + GAIN_W - DUTY_W;

    // synchronised pin vector layout
    localparam int P_MCLK = 0;
    localparam int P_BCLK = 1;
    localparam int P_LR = 2;
    localparam int P_SD1 = 3;
    localparam int P_SD2 = 4;
    localparam int P_FMT = 5;
    localparam int P_SEL = 6;
    localparam int P_MUTE = 7;
    localparam int P_PD = 8;
    localparam int P_RST = 9;
    localparam int P_TEMP = 10;
    localparam int P_UV = 11;
    localparam int P_SHORT = 12;
    localparam int PIN_W = 13;

    typedef enum logic [1:0] {
        SPK_OFF = 2'b00,
        SPK_UP = 2'b01,
        SPK_ON = 2'b10,
        SPK_DOWN = 2'b11
    } spk_state_t;

endpackage

/* File: rtl/audio_input_fault_mute_ctrl.sv */
// serial audio front end, soft mute sequencer and fault latch
// assumes all audio and alarm pins are asynchronous to the core clock
//
// How it works
// - format pin high selects left-justified, low selects I2S decoding.
// - pwm carrier is sixteen times fs, derived from master clock edges.
// - ramp and dc qualification times follow the measured sample rate.
// - only the primary stream drives the speaker pwm path.
// - dac select low gives primary left/right, high gives secondary.
// - frame clock runs at fs; one left and one right word per period.
// - bit clock is 64 fs; one data bit taken per bit clock rise.
// - words of 16, 20 or 24 bits in two's complement are accepted.
// - master clock silent about 1 us while unmuted: soft mute, recover.
// - over-temperature while unmuted soft mutes; clearing soft starts.
// - undervoltage while unmuted soft mutes; recovery soft starts.
// - output short while unmuted forces pwm off at once and latches.
// - duty stuck at 0 or 100 percent for ramp time latches off.
// - open-drain active-low fault flag pulled only for latched faults.
// - latched fault clears only via mute pin low, or reset.
// - dac keeps running through every fault, master clock stop included.
// - mute low holds pwm off; power-down low holds pwm and dac off.
module audio_input_fault_mute_ctrl
    import audio_fault_pkg::*;
#(
    parameter int RAMP_CYC_32K = RAMP_CYC_32K_DEF,
    parameter int RAMP_CYC_44K = RAMP_CYC_44K_DEF,
    parameter int RAMP_CYC_48K = RAMP_CYC_48K_DEF
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic master_audio_clock,
    input wire logic bit_clock,
    input wire logic frame_clock,
    input wire logic primary_serial_data,
    input wire logic secondary_serial_data,
    input wire logic format_select,
    input wire logic dac_source_select,
    input wire logic mute_n_pin,
    input wire logic powerdown_n_pin,
    input wire logic digital_reset_n,
    input wire logic over_temp_alarm,
    input wire logic under_voltage_alarm,
    input wire logic output_short_alarm,
    output logic pwm_left,
    output logic pwm_right,
    output logic output_off_state,
    output logic [WORD_W-1:0] dac_left_out,
    output logic [WORD_W-1:0] dac_right_out,
    output logic dac_drive_en,
    output logic fault_n_o,
    output logic fault_n_oe,
    output logic [1:0] sample_rate_code,
    output logic clock_stopped
);

    // counters must hold the largest time and fit one gain step
    if (RAMP_CYC_32K < GAIN_STEPS || RAMP_CYC_44K < GAIN_STEPS ||
        RAMP_CYC_48K < GAIN_STEPS)
    begin : g_chk_lo
        $error("ramp cycle count below gain step count");
    end
    if (RAMP_CYC_32K >= (1 << TIME_W) || RAMP_CYC_44K >= (1 << TIME_W) ||
        RAMP_CYC_48K >= (1 << TIME_W))
    begin : g_chk_hi
        $error("ramp cycle count exceeds counter width");
    end

    localparam logic [TIME_W-1:0] STEP_32K = TIME_W'(RAMP_CYC_32K / GAIN_STEPS);
    localparam logic [TIME_W-1:0] STEP_44K = TIME_W'(RAMP_CYC_44K / GAIN_STEPS);
    localparam logic [TIME_W-1:0] STEP_48K = TIME_W'(RAMP_CYC_48K / GAIN_STEPS);

    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [STOP_W-1:0] stop_cnt;
        logic clk_stop;
        logic [FRAME_W-1:0] frame_cnt;
        logic [1:0] fs_code;
        logic [PWM_PH_W-1:0] pwm_phase;
        logic lr_bit;
        logic word_left;
        logic [IDX_W-1:0] bit_idx;
        logic [1:0][WORD_W-1:0] shreg;
        logic [1:0][WORD_W-1:0] left_w;
        logic [1:0][WORD_W-1:0] spk_pcm;
        logic [WORD_W-1:0] dac_l;
        logic [WORD_W-1:0] dac_r;
        spk_state_t spk;
        logic [GAIN_W-1:0] gain;
        logic [TIME_W-1:0] step_cnt;
        logic [TIME_W-1:0] dc_cnt;
        logic latched;
        logic [1:0][DUTY_W-1:0] duty;
        logic pwm_l;
        logic pwm_r;
        logic pwm_en;
        logic dac_en;
    } state_t;

    state_t q;
    state_t n;

    // signed sample times gain, mapped to a duty of 0..16 around midscale
    function automatic logic [DUTY_W-1:0] duty_of(
        input logic [WORD_W-1:0] s,
        input logic [GAIN_W-1:0] g
    );
        logic signed [WORD_W+GAIN_W:0] p;
        logic signed [DUTY_W:0] t;
        logic signed [DUTY_W+1:0] v;
        p = $signed(s) * $signed({1'b0, g});
        t = (DUTY_W+1)'(p >>> DUTY_SHIFT);
        v = {t[DUTY_W], t} + $signed({3'h0, DUTY_FULL[DUTY_W-1:1]});
        if (v < 0)
        begin
            duty_of = DUTY_ZERO;
        end
        else if (v > $signed({2'h0, DUTY_FULL}))
        begin
            duty_of = DUTY_FULL;
        end
        else
        begin
            duty_of = v[DUTY_W-1:0];
        end
    endfunction

    // frame period in core cycles to a rate code
    function automatic logic [1:0] fs_of(input logic [FRAME_W-1:0] c);
        if (c > FRAME_SPLIT_LO)
        begin
            fs_of = FS_CODE_32K;
        end
        else if (c > FRAME_SPLIT_HI)
        begin
            fs_of = FS_CODE_44K;
        end
        else
        begin
            fs_of = FS_CODE_48K;
        end
    endfunction

    logic [PIN_W-1:0] pins;
    logic mclk_edge;
    logic mclk_rise;
    logic bclk_rise;
    logic lr_rise;
    logic lr_now;
    logic lj;
    logic mute_off;
    logic pd_off;
    logic run_ok;
    logic hard_off;
    logic latch_set;
    logic step_tick;
    logic dc_stuck;
    logic [TIME_W-1:0] step_lim;
    logic [TIME_W-1:0] dc_lim;

    assign pins = {output_short_alarm, under_voltage_alarm, over_temp_alarm,
                   digital_reset_n, powerdown_n_pin, mute_n_pin,
                   dac_source_select, format_select, secondary_serial_data,
                   primary_serial_data, frame_clock, bit_clock,
                   master_audio_clock};

    always_comb
    begin
        n = q;
        n.s1 = pins;
        n.s2 = q.s1;
        n.s3 = q.s2;
        mclk_edge = q.s2[P_MCLK] ^ q.s3[P_MCLK];
        mclk_rise = q.s2[P_MCLK] & ~q.s3[P_MCLK];
        bclk_rise = q.s2[P_BCLK] & ~q.s3[P_BCLK];
        lr_rise = q.s2[P_LR] & ~q.s3[P_LR];
        lr_now = q.s2[P_LR];
        lj = q.s2[P_FMT];
        mute_off = q.s2[P_MUTE];
        pd_off = ~q.s2[P_PD];

        if (mclk_edge)
        begin
            n.stop_cnt = '0;
            n.clk_stop = 1'b0;
        end
        else if (q.stop_cnt >= CLK_STOP_CYC)
        begin
            n.clk_stop = 1'b1;
        end
        else
        begin
            n.stop_cnt = q.stop_cnt + STOP_W'(1);
        end

        if (lr_rise)
        begin
            n.frame_cnt = '0;
            n.fs_code = fs_of(q.frame_cnt);
        end
        else if (q.frame_cnt != {FRAME_W{1'b1}})
        begin
            n.frame_cnt = q.frame_cnt + FRAME_W'(1);
        end

        // carrier phase, one step per master clock rise
        if (mclk_rise)
        begin
            n.pwm_phase = q.pwm_phase + PWM_PH_W'(1);
        end

        // serial capture on bit clock rise
        if (bclk_rise)
        begin
            n.lr_bit = lr_now;
            if (lr_now != q.lr_bit)
            begin
                // right word done closes the frame
                if (!q.word_left)
                begin
                    n.spk_pcm[0] = q.left_w[0];
                    n.spk_pcm[1] = q.shreg[0];
                    n.dac_l = q.s2[P_SEL] ? q.left_w[1] : q.left_w[0];
                    n.dac_r = q.s2[P_SEL] ? q.shreg[1] : q.shreg[0];
                end
                else
                begin
                    n.left_w = q.shreg;
                end
                n.word_left = lj ? lr_now : ~lr_now;
                n.shreg = '0;
                if (lj)
                begin
                    n.shreg[0][WORD_W-1] = q.s2[P_SD1];
                    n.shreg[1][WORD_W-1] = q.s2[P_SD2];
                    n.bit_idx = IDX_W'(1);
                end
                else
                begin
                    n.bit_idx = '0;
                end
            end
            // msb first, bits past the word width are dropped
            else if (q.bit_idx < IDX_W'(WORD_W))
            begin
                n.shreg[0][WORD_W-1-int'(q.bit_idx)] = q.s2[P_SD1];
                n.shreg[1][WORD_W-1-int'(q.bit_idx)] = q.s2[P_SD2];
                n.bit_idx = q.bit_idx + IDX_W'(1);
            end
        end

        // ramp step and dc time per rate
        case (q.fs_code)
            FS_CODE_32K: step_lim = STEP_32K;
            FS_CODE_44K: step_lim = STEP_44K;
            default: step_lim = STEP_48K;
        endcase
        case (q.fs_code)
            FS_CODE_32K: dc_lim = TIME_W'(RAMP_CYC_32K);
            FS_CODE_44K: dc_lim = TIME_W'(RAMP_CYC_44K);
            default: dc_lim = TIME_W'(RAMP_CYC_48K);
        endcase

        // stuck duty qualification, only while driving
        dc_stuck = q.pwm_en &&
            (q.duty[0] == DUTY_ZERO || q.duty[0] == DUTY_FULL ||
             q.duty[1] == DUTY_ZERO || q.duty[1] == DUTY_FULL);
        n.dc_cnt = dc_stuck ? q.dc_cnt + TIME_W'(1) : '0;

        // latch set wins over the mute clear
        latch_set = (mute_off && q.s2[P_SHORT]) ||
                    (dc_stuck && q.dc_cnt >= dc_lim - TIME_W'(1));
        if (latch_set)
        begin
            n.latched = 1'b1;
        end
        else if (!mute_off)
        begin
            n.latched = 1'b0;
        end

        // soft faults gated by mute pin
        run_ok = ~(mute_off & (q.s2[P_TEMP] | q.s2[P_UV] | q.clk_stop));
        hard_off = pd_off | ~mute_off | q.latched | latch_set;

        step_tick = (q.step_cnt >= step_lim - TIME_W'(1));
        n.step_cnt = step_tick ? '0 : q.step_cnt + TIME_W'(1);

        case (q.spk)
            SPK_OFF:
            begin
                n.gain = '0;
                if (!hard_off && run_ok)
                begin
                    n.spk = SPK_UP;
                end
            end
            SPK_UP:
            begin
                if (!run_ok)
                begin
                    n.spk = SPK_DOWN;
                end
                else if (q.gain == GAIN_MAX)
                begin
                    n.spk = SPK_ON;
                end
                else if (step_tick)
                begin
                    n.gain = q.gain + GAIN_W'(1);
                end
            end
            SPK_ON:
            begin
                if (!run_ok)
                begin
                    n.spk = SPK_DOWN;
                end
            end
            SPK_DOWN:
            begin
                if (run_ok)
                begin
                    n.spk = SPK_UP;
                end
                else if (q.gain == '0)
                begin
                    n.spk = SPK_OFF;
                end
                else if (step_tick)
                begin
                    n.gain = q.gain - GAIN_W'(1);
                end
            end
            default:
            begin
                n.spk = SPK_OFF;
            end
        endcase
        if (hard_off)
        begin
            n.spk = SPK_OFF;
            n.gain = '0;
        end

        // duty follows gain every cycle, registered one cycle behind the gain
        n.duty[0] = duty_of(q.spk_pcm[0], q.gain);
        n.duty[1] = duty_of(q.spk_pcm[1], q.gain);

        // pwm forced off the same cycle as the cause
        n.pwm_en = ~hard_off & (n.spk != SPK_OFF);
        n.pwm_l = n.pwm_en & ({1'b0, q.pwm_phase} < q.duty[0]);
        n.pwm_r = n.pwm_en & ({1'b0, q.pwm_phase} < q.duty[1]);

        n.dac_en = ~pd_off;
        if (pd_off)
        begin
            n.dac_l = '0;
            n.dac_r = '0;
        end

        // digital reset pin: keep only the synchronisers
        if (!q.s2[P_RST])
        begin
            n = '0;
            n.s1 = pins;
            n.s2 = q.s1;
            n.s3 = q.s2;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    assign pwm_left = q.pwm_l;
    assign pwm_right = q.pwm_r;
    assign output_off_state = ~q.pwm_en;
    assign dac_left_out = q.dac_l;
    assign dac_right_out = q.dac_r;
    assign dac_drive_en = q.dac_en;
    // open drain: pull low only while latched
    assign fault_n_o = 1'b0;
    assign fault_n_oe = q.latched;
    assign sample_rate_code = q.fs_code;
    assign clock_stopped = q.clk_stop;

endmodule
